/* core/decoder_control.sv */
// decoder control register with its AHB-Lite slave, search window and sequencer gating
`timescale 1ns/1ps
//Contract
// R1: load half-cell count at each phase-mode cell
// R2: cell centre after count plus one half-cycles
// R3: select field picks search-window pin source
// R4: hit bit sets sequencer flag when enabled
// R5: master disable suppresses all gray decoding
// R6: writing one opens the search window
// R7: sequencer reset-search clears bit, reset wins
// R8: writing zero leaves open-search bit alone
// R9: sector timer held reset while enable low
// R10: branch when bit set and type matches
// R11: write-disable holds qualified write gate low
// R12: run low holds counter zero, outputs zero
// R13: run high starts at instruction zero
// R14: mode bit chosen by alternate field select
// R15: status reset-search write clears search window
// R16: reserved top bit zero, fields reset zero
module decoder_control (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire servo_ctl_pkg::decoder_in_t dec_in,
    output servo_ctl_pkg::decoder_out_t dec_out,
    output logic [4:0] seq_pc,
    output logic [15:0] sector_timer,
    output logic irq
);
    logic [15:0] decoder_control_reg;
    logic search_window;
    logic burst_flag;
    logic [servo_ctl_pkg::irq_w-1:0] irq_status;
    logic [servo_ctl_pkg::irq_w-1:0] irq_mask;
    servo_ctl_pkg::seq_state_t seq_state;
    logic [15:0] next_ctl;
    logic next_search;
    logic next_flag;
    logic [servo_ctl_pkg::irq_w-1:0] next_irq_status;
    logic [servo_ctl_pkg::irq_w-1:0] next_irq_mask;
    servo_ctl_pkg::seq_state_t next_seq_state;
    logic [4:0] next_pc;
    logic [15:0] next_timer;
    logic [31:0] next_hrdata;

    logic dp_write;
    logic [11:0] dp_addr;
    logic next_dp_write;
    logic [11:0] next_dp_addr;
    logic addr_valid;
    logic wr_ctl;
    logic wr_sta;
    logic wr_irq;
    logic wr_mask;
    logic clr_search;
    logic gray_active;
    logic pin_src;
    logic phase_mode;
    logic centre;
    logic running;
    logic [servo_ctl_pkg::irq_w-1:0] irq_events;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_valid = hsel && hready && htrans == servo_ctl_pkg::htrans_nonseq;

    // address phase captured so that the write lands with its data phase
    always_comb begin
        next_dp_write = addr_valid && hwrite;
        next_dp_addr = addr_valid ? haddr : dp_addr;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= servo_ctl_pkg::ctl_addr;
        end else begin
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
        end
    end

    assign wr_ctl = dp_write && dp_addr == servo_ctl_pkg::ctl_addr;
    assign wr_sta = dp_write && dp_addr == servo_ctl_pkg::sta_addr;
    assign wr_irq = dp_write && dp_addr == servo_ctl_pkg::irq_sta_addr;
    assign wr_mask = dp_write && dp_addr == servo_ctl_pkg::irq_mask_addr;

    // control register; open-search bit is set-only from software
    assign clr_search = dec_in.seq_reset_search // R7
        || (wr_sta && hwdata[servo_ctl_pkg::sta_reset_search_window]); // R15

    always_comb begin
        next_ctl = decoder_control_reg;
        if (wr_ctl) begin
            next_ctl = hwdata[15:0] & servo_ctl_pkg::ctl_wmask; // R16
            // a zero written here keeps the bit
            next_ctl[servo_ctl_pkg::open_search_window] = decoder_control_reg[servo_ctl_pkg::open_search_window]
                | hwdata[servo_ctl_pkg::open_search_window]; // R6 R8
        end
        if (clr_search) begin
            next_ctl[servo_ctl_pkg::open_search_window] = 1'b0; // R7
        end
    end

    // window follows the set sources; any reset overrides a simultaneous set
    always_comb begin
        next_search = search_window;
        if (clr_search) begin
            next_search = 1'b0; // R7 R15
        end else if (next_ctl[servo_ctl_pkg::open_search_window] || dec_in.sector_set_search) begin
            next_search = 1'b1; // R6
        end
    end

    assign running = seq_state != servo_ctl_pkg::seq_idle;

    // burst sequencer flag; hardware set wins over clear
    always_comb begin
        next_flag = burst_flag;
        if (dec_in.seq_flag_clear && running) begin
            next_flag = 1'b0;
        end
        if (dec_in.seq_flag_set && running) begin
            next_flag = 1'b1;
        end
        if (decoder_control_reg[servo_ctl_pkg::flag_on_hit] && dec_in.burst_hit_bit) begin
            next_flag = 1'b1; // R4
        end
    end

    // sequencer run gating and instruction counter
    always_comb begin
        next_seq_state = seq_state;
        next_pc = seq_pc;
        unique case (seq_state)
            servo_ctl_pkg::seq_idle: begin
                next_pc = servo_ctl_pkg::pc_start; // R12
                if (decoder_control_reg[servo_ctl_pkg::run_en]) begin
                    next_seq_state = servo_ctl_pkg::seq_start;
                end
            end
            servo_ctl_pkg::seq_start: begin
                next_pc = servo_ctl_pkg::pc_start; // R13
                next_seq_state = servo_ctl_pkg::seq_run;
            end
            servo_ctl_pkg::seq_run: begin
                next_pc = seq_pc + 5'h01;
            end
            default: begin
                next_seq_state = servo_ctl_pkg::seq_idle;
            end
        endcase
        if (!decoder_control_reg[servo_ctl_pkg::run_en]) begin
            next_seq_state = servo_ctl_pkg::seq_idle; // R12
            next_pc = servo_ctl_pkg::pc_start;
        end
    end

    // sector timer counts only while enabled
    always_comb begin
        if (decoder_control_reg[servo_ctl_pkg::timer_en]) begin
            next_timer = sector_timer + servo_ctl_pkg::timer_one;
        end else begin
            next_timer = servo_ctl_pkg::timer_zero; // R9
        end
    end

    // interrupt status: events set, write-one clears, set wins
    assign irq_events[servo_ctl_pkg::irq_mark] = dec_in.timing_mark_found;
    assign irq_events[servo_ctl_pkg::irq_flag] = next_flag && !burst_flag;
    assign irq_events[servo_ctl_pkg::irq_centre] = centre;

    for (genvar i = 0; i < servo_ctl_pkg::irq_w; i++) begin : g_irq_bit
        // an event in the cycle of the clearing write is not lost
        assign next_irq_status[i] = irq_events[i]
            || (irq_status[i] && !(wr_irq && hwdata[i]));
    end

    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_mask) begin
            next_irq_mask = hwdata[servo_ctl_pkg::irq_w-1:0];
        end
    end

    // read mux registered on the address phase; write-through is not needed
    always_comb begin
        next_hrdata = 32'h00000000;
        if (addr_valid && !hwrite) begin
            unique case (haddr)
                servo_ctl_pkg::ctl_addr: next_hrdata[15:0] = decoder_control_reg;
                servo_ctl_pkg::sta_addr: next_hrdata[1] = search_window;
                servo_ctl_pkg::irq_sta_addr: next_hrdata[servo_ctl_pkg::irq_w-1:0] = irq_status;
                servo_ctl_pkg::irq_mask_addr: next_hrdata[servo_ctl_pkg::irq_w-1:0] = irq_mask;
                servo_ctl_pkg::sync_addr: next_hrdata[1:0] = {burst_flag, phase_mode};
                servo_ctl_pkg::seq_pc_addr: next_hrdata[4:0] = seq_pc;
                servo_ctl_pkg::timer_addr: next_hrdata[15:0] = sector_timer;
                default: next_hrdata = 32'h00000000;
            endcase
        end else begin
            next_hrdata = hrdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            decoder_control_reg <= servo_ctl_pkg::ctl_reset; // R16
            search_window <= 1'b0;
        end else begin
            decoder_control_reg <= next_ctl;
            search_window <= next_search;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            burst_flag <= 1'b0;
        end else begin
            burst_flag <= next_flag;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_state <= servo_ctl_pkg::seq_idle;
            seq_pc <= servo_ctl_pkg::pc_start;
        end else begin
            seq_state <= next_seq_state;
            seq_pc <= next_pc;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sector_timer <= servo_ctl_pkg::timer_zero;
        end else begin
            sector_timer <= next_timer;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= '0;
            irq_mask <= '0;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // detection mode chosen by field select
    assign phase_mode = dec_in.alternate_field_select ? dec_in.detect_mode_b
                                                      : dec_in.detect_mode_a; // R14

    half_cell_counter u_half_cell (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(dec_in.cell_start),
        .count(decoder_control_reg[servo_ctl_pkg::hcc_hi:servo_ctl_pkg::hcc_lo]),
        .phase_mode(phase_mode),
        .centre(centre)
    );

    assign gray_active = dec_in.seq_gray_decode_req && running
        && !decoder_control_reg[servo_ctl_pkg::gray_dis]; // R5

    always_comb begin
        unique case (decoder_control_reg[servo_ctl_pkg::sel_hi:servo_ctl_pkg::sel_lo]) // R3
            servo_ctl_pkg::sel_search_window: pin_src = search_window;
            servo_ctl_pkg::sel_hit: pin_src = dec_in.burst_hit_bit;
            servo_ctl_pkg::sel_decoded_bit: pin_src = dec_in.decoded_bit;
            servo_ctl_pkg::sel_cell_clock: pin_src = dec_in.cell_clock;
            servo_ctl_pkg::sel_gray: pin_src = gray_active;
            servo_ctl_pkg::sel_mark: pin_src = dec_in.timing_mark_found;
            servo_ctl_pkg::sel_idx: pin_src = dec_in.index_register_shift_strobe;
            servo_ctl_pkg::sel_gsh: pin_src = dec_in.gray_shift_strobe;
        endcase
    end

    always_comb begin
        dec_out.search_window_pin = pin_src;
        dec_out.search_window = search_window;
        dec_out.gray_decode_active = gray_active;
        dec_out.burst_flag = burst_flag;
        dec_out.take_branch = running && decoder_control_reg[servo_ctl_pkg::burst_branch]
            && dec_in.branch_type_match; // R10 R12
        dec_out.qualified_write_gate = dec_in.write_gate_req
            && !decoder_control_reg[servo_ctl_pkg::write_dis]; // R11
        dec_out.phase_detect = phase_mode;
        dec_out.cell_centre = centre; // R2
        dec_out.timer_reset = !decoder_control_reg[servo_ctl_pkg::timer_en]; // R9
        dec_out.seq_halted = !running; // R12
    end
endmodule // decoder_control

/* core/servo_ctl_pkg.sv */
// package: register map, field layout and shared types of the servo decoder control block
package servo_ctl_pkg;
    localparam logic [11:0] ctl_addr = 12'h000;
    localparam logic [11:0] sta_addr = 12'h004;
    localparam logic [11:0] irq_sta_addr = 12'h008;
    localparam logic [11:0] irq_mask_addr = 12'h00C;
    localparam logic [11:0] sync_addr = 12'h010;
    localparam logic [11:0] seq_pc_addr = 12'h014;
    localparam logic [11:0] timer_addr = 12'h018;

    localparam int hcc_hi = 14;
    localparam int hcc_lo = 10;
    localparam int sel_hi = 9;
    localparam int sel_lo = 7;
    localparam int flag_on_hit = 6;
    localparam int gray_dis = 5;
    localparam int open_search_window = 4;
    localparam int timer_en = 3;
    localparam int burst_branch = 2;
    localparam int write_dis = 1;
    localparam int run_en = 0;
    localparam int sta_reset_search_window = 0;

    localparam logic [15:0] ctl_reset = 16'h0000;
    localparam logic [15:0] ctl_wmask = 16'h7FFF;
    localparam logic [4:0] pc_start = 5'h00;
    localparam logic [4:0] half_cnt_zero = 5'h00;
    localparam logic [4:0] half_cnt_one = 5'h01;
    localparam logic [15:0] timer_one = 16'h0001;
    localparam logic [15:0] timer_zero = 16'h0000;

    localparam int irq_w = 3;
    localparam int irq_mark = 0;
    localparam int irq_flag = 1;
    localparam int irq_centre = 2;

    localparam logic [2:0] sel_search_window = 3'h0;
    localparam logic [2:0] sel_hit = 3'h1;
    localparam logic [2:0] sel_decoded_bit = 3'h2;
    localparam logic [2:0] sel_cell_clock = 3'h3;
    localparam logic [2:0] sel_gray = 3'h4;
    localparam logic [2:0] sel_mark = 3'h5;
    localparam logic [2:0] sel_idx = 3'h6;
    localparam logic [2:0] sel_gsh = 3'h7;

    localparam logic [1:0] htrans_nonseq = 2'h2;

    typedef struct packed {
        logic burst_hit_bit;
        logic decoded_bit;
        logic cell_clock;
        logic timing_mark_found;
        logic index_register_shift_strobe;
        logic gray_shift_strobe;
        logic seq_gray_decode_req;
        logic seq_reset_search;
        logic seq_flag_set;
        logic seq_flag_clear;
        logic branch_type_match;
        logic sector_set_search;
        logic write_gate_req;
        logic cell_start;
        logic read_pulse_trail;
        logic alternate_field_select;
        logic detect_mode_a;
        logic detect_mode_b;
    } decoder_in_t;

    typedef struct packed {
        logic search_window_pin;
        logic search_window;
        logic gray_decode_active;
        logic burst_flag;
        logic take_branch;
        logic qualified_write_gate;
        logic phase_detect;
        logic cell_centre;
        logic timer_reset;
        logic seq_halted;
    } decoder_out_t;

    typedef enum logic [1:0] {
        seq_idle = 2'b00,
        seq_start = 2'b01,
        seq_run = 2'b11
    } seq_state_t;
endpackage

/* core/half_cell_counter.sv */
// half-cell counter that places the centre of each phase-mode bit cell
`timescale 1ns/1ps
module half_cell_counter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic load,
    input wire logic [4:0] count,
    input wire logic phase_mode,
    output logic centre
);
    logic [4:0] remain;
    logic active;
    logic [4:0] next_remain;
    logic next_active;
    logic next_centre;

    // centre falls count+1 half-cycles after the load
    always_comb begin
        next_remain = remain;
        next_active = active;
        next_centre = 1'b0;
        if (load && phase_mode) begin // R1
            next_remain = count;
            next_active = 1'b1;
        end else if (active) begin
            if (remain == servo_ctl_pkg::half_cnt_zero) begin // R2
                next_active = 1'b0;
                next_centre = 1'b1;
            end else begin
                next_remain = remain - servo_ctl_pkg::half_cnt_one;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remain <= servo_ctl_pkg::half_cnt_zero;
            active <= 1'b0;
            centre <= 1'b0;
        end else begin
            remain <= next_remain;
            active <= next_active;
            centre <= next_centre;
        end
    end
endmodule // half_cell_counter

/* tb/decoder_control_sva.sv */
// assertion checker watching the decoder control block ports
`timescale 1ns/1ps
module decoder_control_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire servo_ctl_pkg::decoder_in_t dec_in,
    input wire servo_ctl_pkg::decoder_out_t dec_out,
    input wire logic [4:0] seq_pc,
    input wire logic [15:0] sector_timer,
    input wire logic irq
);
    logic pend;
    logic next_pend;
    logic [15:0] ctl;
    logic [15:0] next_ctl;
    logic [7:0] src;
    // shadow of the control word; its open-search bit is not tracked, so no check relies on it
    always_comb begin
        next_pend = hsel && hready && htrans == servo_ctl_pkg::htrans_nonseq && hwrite
            && haddr == servo_ctl_pkg::ctl_addr;
        next_ctl = pend ? hwdata[15:0] : ctl;
        src = {dec_in.gray_shift_strobe, dec_in.index_register_shift_strobe,
            dec_in.timing_mark_found, dec_out.gray_decode_active, dec_in.cell_clock,
            dec_in.decoded_bit, dec_in.burst_hit_bit, dec_out.search_window};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend <= 1'b0;
            ctl <= 16'h0000;
        end else begin
            pend <= next_pend;
            ctl <= next_ctl;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_mode_select: assert property (dec_out.phase_detect ==
        (dec_in.alternate_field_select ? dec_in.detect_mode_b : dec_in.detect_mode_a))
        else $error("detection mode not taken from the selected bit");
    chk_pin_select: assert property (dec_out.search_window_pin == src[ctl[9:7]])
        else $error("search window pin shows the wrong source");
    chk_wgate_block: assert property (
        dec_out.qualified_write_gate == (dec_in.write_gate_req && !ctl[1]))
        else $error("qualified write gate not blocked by write disable");
    chk_gray_block: assert property (
        dec_out.gray_decode_active |-> dec_in.seq_gray_decode_req && !ctl[5])
        else $error("gray decode active while disabled");
    chk_timer_hold: assert property (!ctl[3] |=> sector_timer == 16'h0000)
        else $error("sector timer not held while disabled");
    chk_timer_count: assert property (
        ctl[3] |=> sector_timer == $past(sector_timer) + 16'h0001)
        else $error("sector timer did not count");
    chk_halt_zero: assert property (!ctl[0] |=> dec_out.seq_halted && seq_pc == 5'h00)
        else $error("sequencer not halted at instruction zero");
    chk_run_start: assert property (
        $rose(ctl[0]) |=> !dec_out.seq_halted && seq_pc == 5'h00)
        else $error("sequencer did not start at instruction zero");
    chk_halt_quiet: assert property (
        dec_out.seq_halted |-> !dec_out.take_branch && !dec_out.gray_decode_active)
        else $error("decoder output active while halted");
    chk_branch_cause: assert property (dec_out.take_branch ==
        (!dec_out.seq_halted && ctl[2] && dec_in.branch_type_match))
        else $error("branch taken without its cause");
    chk_search_clear: assert property (dec_in.seq_reset_search |=> !dec_out.search_window)
        else $error("search window not cleared by reset-search");
    chk_flag_cause: assert property ($rose(dec_out.burst_flag) |->
        $past(dec_in.burst_hit_bit && ctl[6]) || $past(dec_in.seq_flag_set))
        else $error("burst flag rose without a cause");
endmodule // decoder_control_sva

/* tb/testbench.sv */
// self-checking bench for the decoder control block
`timescale 1ns/1ps
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    servo_ctl_pkg::decoder_in_t dec_in = '0;
    servo_ctl_pkg::decoder_out_t dec_out;
    logic [4:0] seq_pc;
    logic [15:0] sector_timer;
    logic irq;
    logic [31:0] seed = 32'h7365;
    logic [31:0] q;
    logic [31:0] r;
    int failures = 0;
    int n_compared = 0;
    int k;

    always #25 hclk = ~hclk;

    decoder_control dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dec_in(dec_in),
        .dec_out(dec_out), .seq_pc(seq_pc), .sector_timer(sector_timer), .irq(irq));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
    endfunction

    // top bit and open-search bit masked: the latter is set-only and tested apart
    function automatic logic [31:0] exp_ctl(input logic [31:0] w);
        return w & 32'h00007FEF;
    endfunction

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_rdy;
        int i;
        i = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            i++;
            if (i > 50) begin
                failures++;
                test_done();
            end
            @(posedge hclk);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= ad;
        htrans <= servo_ctl_pkg::htrans_nonseq;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        chk("hresp", hresp, 32'h0);
    endtask

    // window updates on the data edge itself, so two falling edges are enough
    task automatic win(input string name, input logic exp);
        repeat (2) @(negedge hclk);
        chk(name, dec_out.search_window, exp);
    endtask

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk("halted", dec_out.seq_halted, 32'h1);
        xfer(1'b0, servo_ctl_pkg::ctl_addr, 32'h0);
        chk("ctl_reset", q, 32'h0);
        for (int n = 0; n < 60; n++) begin
            seed = lfsr(seed);
            r = seed;
            dec_in <= r[31:14];
            xfer(1'b1, servo_ctl_pkg::ctl_addr, r);
            xfer(1'b0, servo_ctl_pkg::ctl_addr, 32'h0);
            chk("ctl_rw", q & 32'hFFFFFFEF, exp_ctl(r));
        end
        dec_in <= '0;
        xfer(1'b1, servo_ctl_pkg::ctl_addr, 32'hFFFFFFF8);
        xfer(1'b0, servo_ctl_pkg::ctl_addr, 32'h0);
        chk("ctl_top", q & 32'hFFFFFFEF, 32'h00007FE8);
        xfer(1'b1, servo_ctl_pkg::ctl_addr, 32'h8);
        xfer(1'b0, servo_ctl_pkg::timer_addr, 32'h0);
        r = q;
        xfer(1'b0, servo_ctl_pkg::timer_addr, 32'h0);
        chk("timer_step", q - r, 32'h3);
        xfer(1'b1, servo_ctl_pkg::ctl_addr, 32'h0);
        xfer(1'b0, servo_ctl_pkg::timer_addr, 32'h0);
        chk("timer_held", q, 32'h0);
        xfer(1'b0, servo_ctl_pkg::seq_pc_addr, 32'h0);
        chk("pc_zero", q, 32'h0);
        xfer(1'b1, servo_ctl_pkg::sta_addr, 32'h1);
        win("search_window_closed", 1'b0);
        xfer(1'b1, servo_ctl_pkg::ctl_addr, 32'h10);
        win("search_window_open", 1'b1);
        xfer(1'b1, servo_ctl_pkg::ctl_addr, 32'h0);
        win("search_window_kept", 1'b1);
        xfer(1'b0, servo_ctl_pkg::ctl_addr, 32'h0);
        chk("open_bit", q[4], 32'h1);
        xfer(1'b1, servo_ctl_pkg::sta_addr, 32'h1);
        win("search_window_sta_clr", 1'b0);
        xfer(1'b1, servo_ctl_pkg::ctl_addr, 32'h10);
        dec_in.seq_reset_search <= 1'b1;
        dec_in.sector_set_search <= 1'b1;
        @(posedge hclk);
        dec_in <= '0;
        win("search_window_seq_clr", 1'b0);
        for (int n = 0; n < 2; n++) begin
            r = n ? 32'h00007C00 : 32'h00000C00;
            dec_in.detect_mode_a <= 1'b1;
            xfer(1'b1, servo_ctl_pkg::ctl_addr, r);
            dec_in.cell_start <= 1'b1;
            @(posedge hclk);
            dec_in.cell_start <= 1'b0;
            k = 0;
            @(negedge hclk);
            while (dec_out.cell_centre !== 1'b1 && k < 40) begin
                @(negedge hclk);
                k++;
            end
            chk("centre_delay", k, r[14:10] + 1);
        end
        xfer(1'b1, servo_ctl_pkg::irq_mask_addr, 32'h0);
        xfer(1'b1, servo_ctl_pkg::irq_sta_addr, 32'h7);
        xfer(1'b0, servo_ctl_pkg::irq_sta_addr, 32'h0);
        chk("irq_cleared", q, 32'h0);
        dec_in.timing_mark_found <= 1'b1;
        @(posedge hclk);
        dec_in.timing_mark_found <= 1'b0;
        xfer(1'b0, servo_ctl_pkg::irq_sta_addr, 32'h0);
        chk("irq_event", q, 32'h1);
        @(negedge hclk);
        chk("irq_masked", irq, 32'h0);
        xfer(1'b1, servo_ctl_pkg::irq_mask_addr, 32'h7);
        @(negedge hclk);
        chk("irq_mask", irq, 32'h1);
        xfer(1'b1, servo_ctl_pkg::irq_sta_addr, 32'h1);
        @(negedge hclk);
        chk("irq_low", irq, 32'h0);
        test_done();
    end
endmodule // testbench

bind decoder_control decoder_control_sva chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dec_in(dec_in),
    .dec_out(dec_out), .seq_pc(seq_pc), .sector_timer(sector_timer), .irq(irq));
